// ==== rtl/hwdt_pkg.sv ====
// Purpose: constants and types for the hardware watchdog timer
// Assumes: mclk is the oscillator clock, 125 MHz, one period is one oscillator period
// Notes: register byte address is four times the register index
package hwdt_pkg;
  // clock and machine cycle
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned MC_CLKS = 6;
  localparam logic [2:0] MC_LAST = 3'(MC_CLKS - 1);
  // counter and prescaler sizes, overflow points
  localparam int unsigned CNT_W = 14;
  localparam int unsigned PRE_W = 7;
  localparam logic [13:0] OVF_14 = 14'h3FFF;
  localparam logic [13:0] OVF_10 = 14'h03FF;
  // unlock keys
  localparam logic [7:0] KEY_FIRST = 8'h1E;
  localparam logic [7:0] KEY_SECOND = 8'hE1;
  // register indices, byte address = index * 4
  localparam int unsigned ADDR_W = 12;
  localparam logic [9:0] IDX_RESTART = 10'h0A6;
  localparam logic [9:0] IDX_PRESCALE = 10'h0A7;
  localparam logic [9:0] IDX_STATUS = 10'h0A8;
  // prescale register fields
  localparam int unsigned PRG_W = 4;
  localparam int unsigned PRG_LEN_BIT = 3;
  localparam int unsigned PRG_SEL_LSB = 0;
  localparam int unsigned PRG_SEL_W = 3;
  localparam logic [3:0] PRG_RESET = 4'h0;
  // status register fields
  localparam int unsigned ST_EN_BIT = 0;
  localparam int unsigned ST_ARMED_BIT = 1;
  localparam int unsigned ST_PULSE_BIT = 2;
  // reset pulse: 96 oscillator periods
  localparam int unsigned RST_PULSE_TOSC = 96;
  localparam int unsigned OSC_PERIOD_NS = 8;
  localparam int unsigned RST_PULSE_NS = RST_PULSE_TOSC * OSC_PERIOD_NS;
  localparam int unsigned RST_PULSE_CLKS = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_CNT_W = 7;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // unlock sequence states
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_ARMED = 2'b10
  } hwdt_seq_t;
endpackage

// ==== rtl/hwdt_count.sv ====
// Purpose: prescaler and 14-bit watchdog counter with overflow pulse
// Assumes: run is a one-cycle machine-cycle enable, clr restarts everything
// Notes: count value leaves only for checking, never toward software
`timescale 1ns/1ps
module hwdt_count #(
  parameter int unsigned CNT_W = 14,
  parameter int unsigned PRE_W = 7
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control
  input wire logic clr,
  input wire logic run,
  input wire logic len_10,
  input wire logic [2:0] pre_sel,
  // results
  output logic ovf_q,
  output logic [CNT_W-1:0] cnt_q
);
  logic [PRE_W-1:0] pre_q;
  logic [PRE_W-1:0] pre_mask;
  logic pre_tick;
  logic [CNT_W-1:0] limit;

  // prescaler divides machine cycles by 2^pre_sel
  assign pre_mask = ~({PRE_W{1'b1}} << pre_sel);
  assign pre_tick = run && ((pre_q & pre_mask) == pre_mask);
  assign limit = len_10 ? CNT_W'(hwdt_pkg::OVF_10) : CNT_W'(hwdt_pkg::OVF_14);

  // prescale stage
  always_ff @(posedge mclk) begin
    if (!rst_n || clr) begin
      pre_q <= '0;
    end else if (run) begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // main counter and overflow
  always_ff @(posedge mclk) begin
    if (!rst_n || clr) begin
      cnt_q <= '0;
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= 1'b0;
      if (pre_tick) begin
        if (cnt_q == limit) begin
          cnt_q <= '0;
          ovf_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_ovf_point;
    ovf_q |-> ($past(cnt_q) == ($past(len_10) ? hwdt_pkg::OVF_10 : hwdt_pkg::OVF_14));
  endproperty
  a_ovf_point: assert property (p_ovf_point)
    else $error("overflow not at selected limit");

  property p_pre_gate;
    (cnt_q != $past(cnt_q)) && !$past(clr) && $past(rst_n) && (cnt_q != '0) |-> $past(pre_tick);
  endproperty
  a_pre_gate: assert property (p_pre_gate)
    else $error("counter moved without prescaler tick");

  property p_cov_ovf10;
    ovf_q && len_10;
  endproperty
  c_cov_ovf10: cover property (p_cov_ovf10);
endmodule

// ==== rtl/hwdt_top.sv ====
// Purpose: hardware watchdog timer with unlock sequence and reset-out pulse
// Assumes: AXI4-Lite master, one write and one read at a time
// Notes: overflow resets the watchdog itself and pulses the reset outputs
`timescale 1ns/1ps
module hwdt_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // oscillator state and reset outputs
  input wire logic osc_running,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  output logic sys_reset
);
  // osc synchroniser
  logic osc_meta_q;
  logic osc_sync_q;
  // machine cycle divider
  logic [2:0] mc_div_q;
  logic mc_tick;
  // write channel state
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic aw_have_q;
  logic w_have_q;
  logic [9:0] aw_idx_q;
  logic [7:0] w_data_q;
  logic w_lane0_q;
  logic wr_go;
  logic key_wr;
  logic key_ok;
  logic prg_wr;
  // read channel state
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_val;
  logic [9:0] ar_idx;
  // watchdog state
  hwdt_pkg::hwdt_seq_t seq_q;
  logic en_q;
  logic [hwdt_pkg::PRG_W-1:0] prg_q;
  logic cnt_ovf;
  logic [hwdt_pkg::CNT_W-1:0] cnt_val;
  logic cnt_clr;
  logic cnt_run;
  // reset pulse
  logic [hwdt_pkg::RST_CNT_W-1:0] rst_cnt_q;
  logic rst_pin_q;
  logic sys_reset_q;

  // register index is mapped
  function automatic logic is_mapped(input logic [9:0] idx);
    is_mapped = (idx == hwdt_pkg::IDX_RESTART) ||
                (idx == hwdt_pkg::IDX_PRESCALE) ||
                (idx == hwdt_pkg::IDX_STATUS);
  endfunction

  // bring oscillator state into mclk domain
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      osc_meta_q <= 1'b0;
      osc_sync_q <= 1'b0;
    end else begin
      osc_meta_q <= osc_running;
      osc_sync_q <= osc_meta_q;
    end
  end

  // machine cycle enable, stops with the oscillator
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mc_div_q <= 3'h0;
    end else if (osc_sync_q) begin
      mc_div_q <= (mc_div_q == hwdt_pkg::MC_LAST) ? 3'h0 : mc_div_q + 3'h1;
    end
  end
  assign mc_tick = osc_sync_q && (mc_div_q == hwdt_pkg::MC_LAST);

  // write decode
  assign wr_go = aw_have_q && w_have_q && !bvalid_q;
  assign key_wr = wr_go && w_lane0_q && (aw_idx_q == hwdt_pkg::IDX_RESTART);
  assign prg_wr = wr_go && w_lane0_q && (aw_idx_q == hwdt_pkg::IDX_PRESCALE);
  assign key_ok = key_wr && !rst_pin_q && (seq_q == hwdt_pkg::SEQ_ARMED) &&
                  (w_data_q == hwdt_pkg::KEY_SECOND);

  // write address, data and response channels
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= hwdt_pkg::RESP_OKAY;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_idx_q <= 10'h000;
      w_data_q <= 8'h00;
      w_lane0_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        aw_have_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[11:2];
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
        wready_q <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(aw_idx_q) ? hwdt_pkg::RESP_OKAY : hwdt_pkg::RESP_DECERR;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // unlock sequence tracker, reset also by overflow
  always_ff @(posedge mclk) begin
    if (!rst_n || cnt_ovf) begin
      seq_q <= hwdt_pkg::SEQ_IDLE;
    end else if (key_wr) begin
      unique case (seq_q)
        hwdt_pkg::SEQ_IDLE: begin
          seq_q <= (w_data_q == hwdt_pkg::KEY_FIRST) ? hwdt_pkg::SEQ_ARMED : hwdt_pkg::SEQ_IDLE;
        end
        hwdt_pkg::SEQ_ARMED: begin
          // any value but the first key ends the attempt
          seq_q <= (w_data_q == hwdt_pkg::KEY_FIRST) ? hwdt_pkg::SEQ_ARMED : hwdt_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // enable: set by sequence, cleared only by reset or overflow
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      en_q <= 1'b0;
    end else if (cnt_ovf) begin
      en_q <= 1'b0;
    end else if (key_ok) begin
      en_q <= 1'b1;
    end
  end

  // prescale register: length select and prescale select
  always_ff @(posedge mclk) begin
    if (!rst_n || cnt_ovf) begin
      prg_q <= hwdt_pkg::PRG_RESET;
    end else if (prg_wr) begin
      prg_q <= w_data_q[hwdt_pkg::PRG_W-1:0];
    end
  end

  // counter control
  assign cnt_clr = !en_q || key_ok;
  assign cnt_run = en_q && mc_tick;
  hwdt_count #(
    .CNT_W(hwdt_pkg::CNT_W),
    .PRE_W(hwdt_pkg::PRE_W)
  ) u_count (
    .mclk(mclk),
    .rst_n(rst_n),
    .clr(cnt_clr),
    .run(cnt_run),
    .len_10(prg_q[hwdt_pkg::PRG_LEN_BIT]),
    .pre_sel(prg_q[hwdt_pkg::PRG_SEL_LSB +: hwdt_pkg::PRG_SEL_W]),
    .ovf_q(cnt_ovf),
    .cnt_q(cnt_val)
  );

  // reset pulse on pin and to the controller
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rst_cnt_q <= '0;
      rst_pin_q <= 1'b0;
      sys_reset_q <= 1'b0;
    end else if (cnt_ovf) begin
      rst_cnt_q <= hwdt_pkg::RST_CNT_W'(hwdt_pkg::RST_PULSE_CLKS - 1);
      rst_pin_q <= 1'b1;
      sys_reset_q <= 1'b1;
    end else if (rst_cnt_q != '0) begin
      rst_cnt_q <= rst_cnt_q - 1'b1;
    end else begin
      rst_pin_q <= 1'b0;
      sys_reset_q <= 1'b0;
    end
  end

  // read data select, restart register reads as zero
  assign ar_idx = s_axi_araddr[11:2];
  always_comb begin
    rd_val = 32'h0000_0000;
    if (ar_idx == hwdt_pkg::IDX_PRESCALE) begin
      rd_val[hwdt_pkg::PRG_W-1:0] = prg_q;
    end else if (ar_idx == hwdt_pkg::IDX_STATUS) begin
      rd_val[hwdt_pkg::ST_EN_BIT] = en_q;
      rd_val[hwdt_pkg::ST_ARMED_BIT] = (seq_q == hwdt_pkg::SEQ_ARMED);
      rd_val[hwdt_pkg::ST_PULSE_BIT] = rst_pin_q;
    end
  end

  // read address and data channels
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= hwdt_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= is_mapped(ar_idx) ? hwdt_pkg::RESP_OKAY : hwdt_pkg::RESP_DECERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // outputs straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign rst_pin_out = rst_pin_q;
  assign rst_pin_oe = rst_pin_q;
  assign sys_reset = sys_reset_q;
  // length of reset pulse, for checking only
  logic [7:0] hi_len_q;
  always_ff @(posedge mclk) begin
    if (!rst_n || !rst_pin_q) begin
      hi_len_q <= 8'h00;
    end else begin
      hi_len_q <= hi_len_q + 8'h01;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_dis_reset;
    $rose(rst_n) |-> !en_q && (cnt_val == '0);
  endproperty
  a_dis_reset: assert property (p_dis_reset)
    else $error("watchdog not disabled after reset");
  // an overflow in the same cycle wins over the sequence
  property p_enable;
    key_ok && !cnt_ovf |=> en_q ##0 (cnt_val == '0);
  endproperty
  a_enable: assert property (p_enable)
    else $error("sequence did not enable and clear the watchdog");
  property p_restart;
    key_ok && en_q && !cnt_ovf |=> (cnt_val == '0) && en_q;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart sequence did not clear counter");
  property p_no_disable;
    $fell(en_q) |-> $past(cnt_ovf);
  endproperty
  a_no_disable: assert property (p_no_disable)
    else $error("watchdog disabled without overflow");
  property p_mc_rate;
    mc_tick |=> !mc_tick [*5];
  endproperty
  a_mc_rate: assert property (p_mc_rate)
    else $error("machine cycle shorter than six clocks");
  // counter holds its value while the oscillator is stopped
  property p_osc_stop;
    !osc_sync_q && en_q && !key_ok |=> $stable(cnt_val);
  endproperty
  a_osc_stop: assert property (p_osc_stop)
    else $error("counting while oscillator stopped");
  property p_ovf_reset;
    cnt_ovf |=> sys_reset_q && rst_pin_q && !en_q;
  endproperty
  a_ovf_reset: assert property (p_ovf_reset)
    else $error("overflow did not raise reset");
  property p_pulse_len;
    $fell(rst_pin_q) |-> (hi_len_q == 8'(hwdt_pkg::RST_PULSE_CLKS));
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("reset pulse length wrong");
  property p_restart_ro;
    s_axi_arvalid && arready_q && (ar_idx == hwdt_pkg::IDX_RESTART) |=> (rdata_q == 32'h0000_0000);
  endproperty
  a_restart_ro: assert property (p_restart_ro)
    else $error("restart register read returned data");
  property p_discard;
    key_wr && (w_data_q != hwdt_pkg::KEY_FIRST) |=> (seq_q == hwdt_pkg::SEQ_IDLE);
  endproperty
  a_discard: assert property (p_discard)
    else $error("partial sequence not discarded");
  property p_cov_enable;
    key_ok && !en_q;
  endproperty
  c_cov_enable: cover property (p_cov_enable);
  property p_cov_restart;
    key_ok && en_q;
  endproperty
  c_cov_restart: cover property (p_cov_restart);
  property p_cov_ovf;
    cnt_ovf;
  endproperty
  c_cov_ovf: cover property (p_cov_ovf);
endmodule

// ==== bench/hwdt_top_tb_top.sv ====
// Purpose: self-checking bench for the hardware watchdog timer
// Assumes: 10-bit overflow with prescale select 0 or 1 keeps each time-out near 6k or 12k cycles
// Notes: 14-bit and long prescale limits are left to the design's own assertions
`timescale 1ns/1ps
module hwdt_top_tb_top;
  localparam logic [11:0] A_RST = {hwdt_pkg::IDX_RESTART, 2'b00};
  localparam logic [11:0] A_PRG = {hwdt_pkg::IDX_PRESCALE, 2'b00};
  localparam logic [11:0] A_ST = {hwdt_pkg::IDX_STATUS, 2'b00};
  localparam logic [11:0] A_BAD = 12'h004;
  localparam int TICK = 6;
  localparam int LIMIT = 80000;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h000;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic osc_running = 1'b1;
  logic rst_pin_out;
  logic rst_pin_oe;
  logic sys_reset;
  logic [1:0] resp;
  logic [31:0] d;
  int pulse_edges = 0;
  int base = 0;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;

  // clock, 8 ns period
  always #4 mclk = ~mclk;

  hwdt_top u_hwdt_top (
    .mclk(mclk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .osc_running(osc_running),
    .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .sys_reset(sys_reset)
  );

  // hang guard and count of edges with the reset pin high
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (rst_pin_out === 1'b1) pulse_edges <= pulse_edges + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one write; address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    bit done = 0;
    int k = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done && k < 100) begin
      @(posedge mclk);
      k++;
      if (s_axi_awvalid === 1'b1 && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid === 1'b1 && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        done = 1;
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    if (!done) check(32'h0, 32'h1);
  endtask

  // one read; ready held until the data is seen
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    bit done = 0;
    int k = 0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done && k < 100) begin
      @(posedge mclk);
      k++;
      if (s_axi_arvalid === 1'b1 && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        done = 1;
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
    if (!done) check(32'h0, 32'h1);
  endtask

  task automatic enable(input logic [2:0] s);
    wr(A_PRG, {28'h0, 1'b1, s});
    wr(A_RST, 32'h0000_001E);
    wr(A_RST, 32'h0000_00E1);
    base = pulse_edges;
  endtask

  // edges until the reset pin is seen high
  task automatic wait_rise(output int c);
    c = 0;
    do begin
      @(posedge mclk);
      c++;
    end while (rst_pin_out !== 1'b1 && c < 30000);
  endtask

  // pulse length and agreement of the three reset outputs, then state after it
  task automatic pulse_check();
    int w = 0;
    logic bad = 1'b0;
    while (rst_pin_out === 1'b1 && w < 200) begin
      if (sys_reset !== 1'b1 || rst_pin_oe !== 1'b1) bad = 1'b1;
      w++;
      @(posedge mclk);
    end
    check(32'(w), 32'(hwdt_pkg::RST_PULSE_TOSC));
    check({31'h0, bad}, 32'h0);
    check({30'h0, sys_reset, rst_pin_oe}, 32'h0);
    rd(A_ST, d);
    check(d, 32'h0);
    rd(A_PRG, d);
    check(d, 32'(hwdt_pkg::PRG_RESET));
  endtask

  task automatic window(input int c, input int lo, input int hi);
    check(32'((c >= lo && c <= hi) ? lo : c), 32'(lo));
  endtask

  task automatic t_reset();
    check({31'h0, s_axi_awready}, 32'h1);
    rd(A_ST, d);
    check(d, 32'h0);
    rd(A_RST, d);
    check(d, 32'h0);
    rd(A_PRG, d);
    check(d, 32'(hwdt_pkg::PRG_RESET));
    wr(A_BAD, 32'h0000_001E);
    check(32'(resp), 32'(hwdt_pkg::RESP_DECERR));
    rd(A_BAD, d);
    check(32'(resp), 32'(hwdt_pkg::RESP_DECERR));
    wr(A_PRG, 32'hFFFF_FFFB);
    check(32'(resp), 32'(hwdt_pkg::RESP_OKAY));
    rd(A_PRG, d);
    check(d, 32'h0000_000B);
    wr(A_PRG, 32'h0000_0008);
    repeat (7000) @(posedge mclk);
    check(32'(pulse_edges - base), 32'h0);
  endtask

  task automatic t_sequence();
    wr(A_RST, 32'h0000_001E);
    rd(A_ST, d);
    check(d, 32'h2);
    wr(A_RST, 32'h0000_0055);
    rd(A_ST, d);
    check(d, 32'h0);
    wr(A_RST, 32'h0000_00E1);
    rd(A_ST, d);
    check(d, 32'h0);
    wr(A_RST, 32'h0000_001E);
    wr(A_PRG, 32'h0000_0008);
    wr(A_RST, 32'h0000_00E1);
    rd(A_ST, d);
    check({31'h0, d[0]}, 32'h1);
    wr(A_RST, 32'h0000_0000);
    wr(A_RST, 32'h0000_001E);
    wr(A_RST, 32'h0000_0077);
    rd(A_ST, d);
    check({31'h0, d[0]}, 32'h1);
    wait_rise(n);
    check({31'h0, rst_pin_out}, 32'h1);
    pulse_check();
  endtask

  // time-out length for a given prescale select in 10-bit mode
  task automatic t_overflow(input logic [2:0] s);
    int e;
    e = 1024 * TICK * (1 << s);
    enable(s);
    wait_rise(n);
    window(n, e - 8, e + 14);
    pulse_check();
  endtask

  task automatic t_restart();
    enable(3'h0);
    repeat (800 * TICK) @(posedge mclk);
    wr(A_RST, 32'h0000_001E);
    wr(A_RST, 32'h0000_00E1);
    repeat (800 * TICK) @(posedge mclk);
    check(32'(pulse_edges - base), 32'h0);
    wait_rise(n);
    window(n, 224 * TICK - 8, 224 * TICK + 14);
    pulse_check();
  endtask

  // hardware reset in mid-run disables an enabled watchdog
  task automatic t_hw_reset();
    enable(3'h0);
    repeat (100 * TICK) @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(A_ST, d);
    check(d, 32'h0);
    rd(A_PRG, d);
    check(d, 32'(hwdt_pkg::PRG_RESET));
    repeat (1100 * TICK) @(posedge mclk);
    check(32'(pulse_edges - base), 32'h0);
  endtask

  task automatic t_osc_stop();
    enable(3'h0);
    repeat (500 * TICK) @(posedge mclk);
    osc_running <= 1'b0;
    repeat (3000) @(posedge mclk);
    check(32'(pulse_edges - base), 32'h0);
    osc_running <= 1'b1;
    wait_rise(n);
    window(n, 524 * TICK - 10, 524 * TICK + 20);
    pulse_check();
  endtask

  // reset for two cycles, then each scenario in turn
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_sequence();
    t_overflow(3'h0);
    t_overflow(3'h1);
    t_restart();
    t_hw_reset();
    t_osc_stop();
    end_sim();
  end
endmodule
